// >>> pkg/input_cond_pkg.sv
package input_cond_pkg;

    localparam int NUM_TERM    = 7;
    localparam int CODE_W      = 8;
    localparam int RESP_W      = 8;
    localparam int DATA_W      = 32;
    localparam int ADDR_W      = 8;
    localparam int FUNC_COUNT  = 256;
    localparam int SYNC_STAGES = 3;

    // Register byte offsets, one aligned word per setting
    localparam logic [7:0] FUNC_BASE   = 8'h00;
    localparam logic [7:0] POL_BASE    = 8'h20;
    localparam logic [7:0] RESP_BASE   = 8'h40;
    localparam logic [7:0] STATUS_OFS  = 8'h60;
    localparam logic [7:0] ACTIVE_OFS  = 8'h64;
    localparam logic [7:0] RUN_OFS     = 8'h68;

    // Option codes hold the decimal code value
    localparam logic [7:0] OPT_FORWARD_RUN   = 8'h00;
    localparam logic [7:0] OPT_REVERSE_RUN   = 8'h01;
    localparam logic [7:0] OPT_SPEED_BIT0    = 8'h02;
    localparam logic [7:0] OPT_SPEED_BIT1    = 8'h03;
    localparam logic [7:0] OPT_TWO_STAGE     = 8'h09;
    localparam logic [7:0] OPT_START_GUARD   = 8'h0D;
    localparam logic [7:0] OPT_FAULT_RESET   = 8'h12;

    localparam logic [7:0] FUNC_RESET [NUM_TERM] = '{
        OPT_FORWARD_RUN, OPT_REVERSE_RUN, OPT_SPEED_BIT0, OPT_SPEED_BIT1,
        OPT_TWO_STAGE, OPT_FAULT_RESET, OPT_START_GUARD
    };

    localparam logic [7:0] POL_NORMALLY_OPEN   = 8'h00;
    localparam logic [7:0] POL_NORMALLY_CLOSED = 8'h01;

    localparam logic [7:0] RESP_MAX   = 8'hC8;
    localparam logic [7:0] RESP_RESET = 8'h01;

    localparam int RESP_UNIT_NS     = 2_000_000;
    localparam int CLK_PERIOD_NS    = 4;
    localparam int RESP_UNIT_CYCLES = RESP_UNIT_NS / CLK_PERIOD_NS;

    localparam logic [2:0] BOOT_WAIT = 3'h4;

    typedef enum logic [1:0] {
        BOOT_SYNC  = 2'b00,
        BOOT_PRIME = 2'b01,
        BOOT_RUN   = 2'b11
    } boot_e;

endpackage

// >>> pkg/cond_filter_if.sv
interface cond_filter_if #(
    parameter int N  = 7,
    parameter int RW = 8
);
    logic [N-1:0]  level;
    logic [RW-1:0] resp [N];
    logic          tick;
    logic          prime;
    logic [N-1:0]  filtered;

    modport ctrl (output level, output resp, output tick, output prime, input filtered);
    modport filt (input level, input resp, input tick, input prime, output filtered);
endinterface

// >>> rtl/response_filter_bank.sv
module response_filter_bank #(
    parameter int N  = 7,
    parameter int RW = 8
) (
    input  wire logic  clk,
    input  wire logic  arst_n,
    cond_filter_if.filt fi
);

    logic [RW-1:0] count [N];
    logic [N-1:0]  stable;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stable <= '0;
            for (int i = 0; i < N; i++) begin
                count[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (fi.prime) begin
                    // Power-on value taken without waiting
                    stable[i] <= fi.level[i];
                    count[i]  <= '0;
                end else if (fi.level[i] == stable[i]) begin
                    count[i] <= '0;
                end else if (fi.resp[i] == '0) begin
                    stable[i] <= fi.level[i];
                end else if (fi.tick) begin
                    if (count[i] + RW'(1) >= fi.resp[i]) begin
                        stable[i] <= fi.level[i];
                        count[i]  <= '0;
                    end else begin
                        count[i] <= count[i] + RW'(1);
                    end
                end
            end
        end
    end

    assign fi.filtered = stable;

endmodule

// >>> rtl/input_terminal_conditioner.sv
// Summary of operation
// - Seven input terminals, each with its own function selector register.
// - A selector value is a discrete option code, never a quantity.
// - Reset selectors: codes 00, 01, 02, 03, 09, 18, 13 on terminals one to seven.
// - Each terminal has its own polarity setting inverting only that terminal.
// - By default a high terminal level counts as active.
// - Polarity 00 passes the level, 01 inverts it; all reset to 00.
// - Fault-reset terminals refuse normally closed and always act active high.
// - Response time per terminal is 0 to 200 steps of 2 ms.
// - Every response-time setting resets to one step of 2 ms.
// - After reset the filter is bypassed; active inputs act once startup ends.
// - A function assigned to several terminals is active when any is active.
// - Each input is a binary value: inactive reads 0, active reads 1.
//
// The Avalon-MM slave port and the register offsets were decided locally.
module input_terminal_conditioner #(
    parameter int TICK_CYCLES = input_cond_pkg::RESP_UNIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [6:0]  terminal_in,
    input  wire logic        drive_running,
    output logic      [255:0] function_active,
    output logic      [6:0]  terminal_level,
    output logic             inputs_ready,
    output logic             forward_run_cmd,
    output logic             reverse_run_cmd,
    output logic             speed_sel_bit0,
    output logic             speed_sel_bit1,
    output logic             two_stage_ramp_sel,
    output logic             fault_reset_cmd,
    output logic             unattended_start_guard
);

    localparam int N  = input_cond_pkg::NUM_TERM;
    localparam int RW = input_cond_pkg::RESP_W;
    localparam int CW = input_cond_pkg::CODE_W;

    // Settings registers
    logic [CW-1:0] func_sel [N];
    logic [N-1:0]  pol_nc;
    logic [RW-1:0] resp_time [N];

    // Input synchronisers
    logic [N-1:0]  sync1;
    logic [N-1:0]  sync2;
    logic [N-1:0]  sync3;
    logic [N-1:0]  accepted;

    logic [N-1:0]  effective_nc;
    logic [31:0]   tick_cnt;
    logic          tick;
    input_cond_pkg::boot_e boot_state;
    logic [2:0]    boot_cnt;
    logic          ack;
    logic          wr_go;
    logic          wr_allowed;

    // Bus decode and write qualifiers
    logic          sel_func;
    logic          sel_pol;
    logic          sel_resp;
    logic          sel_status;
    logic          sel_active;
    logic          sel_run;
    logic [2:0]    reg_idx;
    logic          func_wr;
    logic          pol_wr;
    logic          resp_wr;
    logic          pol_code_no;
    logic          pol_code_nc;
    logic          resp_in_range;
    logic [31:0]   next_readdata;
    logic [255:0]  next_function_active;

    cond_filter_if #(.N(N), .RW(RW)) fif ();

    function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        in_block = (a >= base) && (off < 8'(4 * N)) && (off[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] term_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        term_idx = off[4:2];
    endfunction

    // Address decode: one select per register group, terminal index from the word offset
    always_comb begin
        sel_func   = 1'b0;
        sel_pol    = 1'b0;
        sel_resp   = 1'b0;
        sel_status = 1'b0;
        sel_active = 1'b0;
        sel_run    = 1'b0;
        reg_idx    = 3'h0;
        if (in_block(address, input_cond_pkg::FUNC_BASE)) begin
            sel_func = 1'b1;
            reg_idx  = term_idx(address, input_cond_pkg::FUNC_BASE);
        end else if (in_block(address, input_cond_pkg::POL_BASE)) begin
            sel_pol = 1'b1;
            reg_idx = term_idx(address, input_cond_pkg::POL_BASE);
        end else if (in_block(address, input_cond_pkg::RESP_BASE)) begin
            sel_resp = 1'b1;
            reg_idx  = term_idx(address, input_cond_pkg::RESP_BASE);
        end else if (address == input_cond_pkg::STATUS_OFS) begin
            sel_status = 1'b1;
        end else if (address == input_cond_pkg::ACTIVE_OFS) begin
            sel_active = 1'b1;
        end else if (address == input_cond_pkg::RUN_OFS) begin
            sel_run = 1'b1;
        end
    end

    // Bus handshake: one wait cycle, then the answer
    assign waitrequest = (read | write) & ~ack;
    assign wr_go       = write & ack & byteenable[0];
    assign wr_allowed  = wr_go & ~drive_running;

    // Per-group write strobes; a refused value leaves the setting untouched
    assign func_wr       = wr_allowed & sel_func;
    assign pol_wr        = wr_allowed & sel_pol;
    assign resp_wr       = wr_allowed & sel_resp;
    assign pol_code_no   = (writedata[7:0] == input_cond_pkg::POL_NORMALLY_OPEN);
    assign pol_code_nc   = (writedata[7:0] == input_cond_pkg::POL_NORMALLY_CLOSED) &&
                           (func_sel[reg_idx] != input_cond_pkg::OPT_FAULT_RESET);
    assign resp_in_range = (writedata <= 32'(input_cond_pkg::RESP_MAX));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
        end else begin
            // Ack lasts one cycle, so every request sees exactly one wait cycle
            ack <= (read | write) & ~ack;
        end
    end

    // Function selectors
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < N; i++) begin
                func_sel[i] <= input_cond_pkg::FUNC_RESET[i];
            end
        end else if (func_wr) begin
            // Any code stored as-is: it selects, it does not scale
            func_sel[reg_idx] <= writedata[CW-1:0];
        end
    end

    // Polarity settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pol_nc <= '0;
        end else if (pol_wr) begin
            if (pol_code_no) begin
                pol_nc[reg_idx] <= 1'b0;
            end else if (pol_code_nc) begin
                pol_nc[reg_idx] <= 1'b1;
            end
        end
    end

    // Response-time settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < N; i++) begin
                resp_time[i] <= input_cond_pkg::RESP_RESET;
            end
        end else if (resp_wr) begin
            if (resp_in_range) begin
                resp_time[reg_idx] <= writedata[RW-1:0];
            end
        end
    end

    // Read mux; the word is registered in the wait cycle and stands at completion
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (sel_func) begin
            next_readdata = 32'(func_sel[reg_idx]);
        end else if (sel_pol) begin
            next_readdata = 32'(pol_nc[reg_idx]);
        end else if (sel_resp) begin
            next_readdata = 32'(resp_time[reg_idx]);
        end else if (sel_status) begin
            next_readdata = {15'h0000, inputs_ready, 1'b0, accepted, 1'b0, terminal_level};
        end else if (sel_active) begin
            next_readdata = function_active[31:0];
        end else if (sel_run) begin
            next_readdata = {31'h0000_0000, drive_running};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata <= '0;
        end else if (read && !ack) begin
            readdata <= next_readdata;
        end
    end

    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= terminal_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            accepted <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (sync2[i] == sync3[i]) begin
                    accepted[i] <= sync3[i];
                end
            end
        end
    end

    // Fault-reset terminals are forced active high
    always_comb begin
        for (int i = 0; i < N; i++) begin
            effective_nc[i] = pol_nc[i] & (func_sel[i] != input_cond_pkg::OPT_FAULT_RESET);
        end
    end

    // 2 ms step generator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'd1;
            tick     <= 1'b0;
        end
    end

    // Startup: wait for the synchronisers, then load filters directly
    // Four counted edges cover the three flops and the agreement stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_state <= input_cond_pkg::BOOT_SYNC;
            boot_cnt   <= '0;
        end else begin
            case (boot_state)
                input_cond_pkg::BOOT_SYNC: begin
                    if (boot_cnt == input_cond_pkg::BOOT_WAIT) begin
                        boot_state <= input_cond_pkg::BOOT_PRIME;
                    end else begin
                        boot_cnt <= boot_cnt + 3'd1;
                    end
                end
                input_cond_pkg::BOOT_PRIME: begin
                    boot_state <= input_cond_pkg::BOOT_RUN;
                end
                input_cond_pkg::BOOT_RUN: begin
                    boot_state <= input_cond_pkg::BOOT_RUN;
                end
                default: begin
                    boot_state <= input_cond_pkg::BOOT_SYNC;
                end
            endcase
        end
    end

    assign fif.level = accepted ^ effective_nc;
    assign fif.tick  = tick;
    assign fif.prime = (boot_state == input_cond_pkg::BOOT_PRIME);
    always_comb begin
        for (int i = 0; i < N; i++) begin
            fif.resp[i] = resp_time[i];
        end
    end

    response_filter_bank #(.N(N), .RW(RW)) u_filter (
        .clk    (clk),
        .arst_n (arst_n),
        .fi     (fif)
    );

    // Function map: OR of every terminal holding the code
    always_comb begin
        next_function_active = '0;
        for (int i = 0; i < N; i++) begin
            if (fif.filtered[i]) begin
                next_function_active[func_sel[i]] = 1'b1;
            end
        end
    end

    // Outputs stay quiet until startup has primed the filters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inputs_ready <= 1'b0;
        end else begin
            inputs_ready <= (boot_state == input_cond_pkg::BOOT_RUN);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            terminal_level <= '0;
        end else if (boot_state == input_cond_pkg::BOOT_RUN) begin
            terminal_level <= fif.filtered;
        end else begin
            terminal_level <= '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            function_active <= '0;
        end else if (boot_state == input_cond_pkg::BOOT_RUN) begin
            function_active <= next_function_active;
        end else begin
            function_active <= '0;
        end
    end

    assign forward_run_cmd        = function_active[input_cond_pkg::OPT_FORWARD_RUN];
    assign reverse_run_cmd        = function_active[input_cond_pkg::OPT_REVERSE_RUN];
    assign speed_sel_bit0         = function_active[input_cond_pkg::OPT_SPEED_BIT0];
    assign speed_sel_bit1         = function_active[input_cond_pkg::OPT_SPEED_BIT1];
    assign two_stage_ramp_sel     = function_active[input_cond_pkg::OPT_TWO_STAGE];
    assign fault_reset_cmd        = function_active[input_cond_pkg::OPT_FAULT_RESET];
    assign unattended_start_guard = function_active[input_cond_pkg::OPT_START_GUARD];

endmodule

// >>> test/term_contacts.sv
module term_contacts (
    input  wire logic       clk,
    input  wire logic [6:0] want,
    input  wire logic [3:0] lag,
    output logic      [6:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slow contacts show the commanded level only after lag cycles
    logic [6:0] dly [16];
    always_ff @(posedge clk) begin
        dly[0] <= want;
        for (int i = 1; i < 16; i++) begin
            dly[i] <= dly[i-1];
        end
    end
    assign pins = (lag == 4'h0) ? want : dly[lag-4'h1];
endmodule

// >>> test/term_cond_props.sv
module term_cond_props #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic         clk,
    input wire logic         arst_n,
    input wire logic [7:0]   address,
    input wire logic         read,
    input wire logic         write,
    input wire logic [31:0]  readdata,
    input wire logic         waitrequest,
    input wire logic [255:0] function_active,
    input wire logic         inputs_ready,
    input wire logic         forward_run_cmd,
    input wire logic         reverse_run_cmd,
    input wire logic         speed_sel_bit0,
    input wire logic         speed_sel_bit1,
    input wire logic         two_stage_ramp_sel,
    input wire logic         fault_reset_cmd,
    input wire logic         unattended_start_guard
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic rd_done;
    assign rd_done = read & ~waitrequest;

    wait_first_a: assert property ((read || write) && !$past(read || write) |-> waitrequest)
        else $error("first request cycle not stalled");
    wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request stalled more than one cycle");
    port_map_a: assert property ({unattended_start_guard, fault_reset_cmd, two_stage_ramp_sel, speed_sel_bit1,
        speed_sel_bit0, reverse_run_cmd, forward_run_cmd} == {function_active[13], function_active[18],
        function_active[9], function_active[3:0]})
        else $error("named output differs from function vector");
    boot_quiet_a: assert property (!inputs_ready |-> function_active == '0)
        else $error("function active before startup");
    ready_hold_a: assert property (inputs_ready |=> inputs_ready)
        else $error("ready dropped without reset");
    ready_soon_a: assert property (!inputs_ready |-> ##[1:12] inputs_ready)
        else $error("startup too slow");
    pol_range_a: assert property (rd_done && address[7:5] == 3'h1 |-> readdata[31:1] == '0)
        else $error("polarity readback out of range");
    resp_range_a: assert property (rd_done && address[7:5] == 3'h2 |-> readdata <= 32'h0000_00c8)
        else $error("response time readback above limit");
    unmapped_zero_a: assert property (rd_done && address >= 8'h6c |-> readdata == '0)
        else $error("unmapped read not zero");

    cover property (write && !waitrequest && address[7:5] == 3'h1);
    cover property ($rose(fault_reset_cmd));
    cover property ($rose(inputs_ready));
endmodule

bind input_terminal_conditioner term_cond_props #(.TICK_CYCLES(TICK_CYCLES)) props (
    .clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .function_active(function_active), .inputs_ready(inputs_ready),
    .forward_run_cmd(forward_run_cmd), .reverse_run_cmd(reverse_run_cmd), .speed_sel_bit0(speed_sel_bit0),
    .speed_sel_bit1(speed_sel_bit1), .two_stage_ramp_sel(two_stage_ramp_sel),
    .fault_reset_cmd(fault_reset_cmd), .unattended_start_guard(unattended_start_guard));

// >>> test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    logic clk = 0, arst_n = 0, read = 0, write = 0, drive_running = 0;
    logic [7:0]   address = '0;
    logic [31:0]  writedata = '0, readdata;
    logic [3:0]   byteenable = 4'hf, lag = 4'h0;
    logic [6:0]   terminal_in, terminal_level, want = 7'h01;
    logic [255:0] function_active;
    logic         waitrequest, inputs_ready;
    int num_errors = 0, checks = 0;
    int fn[7], pl[7], rt[7];

    always #2 clk = ~clk;

    input_terminal_conditioner #(.TICK_CYCLES(TICK)) dut (
        .clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .terminal_in(terminal_in),
        .drive_running(drive_running), .function_active(function_active), .terminal_level(terminal_level),
        .inputs_ready(inputs_ready), .forward_run_cmd(), .reverse_run_cmd(), .speed_sel_bit0(),
        .speed_sel_bit1(), .two_stage_ramp_sel(), .fault_reset_cmd(), .unattended_start_guard());
    term_contacts sw (.clk(clk), .want(want), .lag(lag), .pins(terminal_in));

    task automatic end_sim;
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic bus(input int a, input logic w, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        logic wq;
        @(posedge clk);
        address <= a[7:0];
        read <= !w;
        write <= w;
        writedata <= d;
        byteenable <= be;
        // Answer taken at the rising edge itself, before that edge updates it
        do begin
            @(posedge clk);
            wq = waitrequest;
            q = readdata;
        end while (wq !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input int a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        logic [31:0] q;
        int i;
        i = (a % 32) / 4;
        bus(a, 1'b1, d, be, q);
        if (!drive_running && be[0] && i < 7) begin
            if (a < 32) fn[i] = d[7:0];
            else if (a < 64) begin
                if (d < 2 && !(d == 1 && fn[i] == 18)) pl[i] = d;
            end else if (a < 96 && d <= 200) rt[i] = d;
        end
    endtask

    task automatic rdall;
        logic [31:0] q;
        for (int i = 0; i < 7; i++) begin
            bus(4 * i, 1'b0, '0, 4'hf, q);
            chk(q, fn[i]);
            bus(32 + 4 * i, 1'b0, '0, 4'hf, q);
            chk(q, pl[i]);
            bus(64 + 4 * i, 1'b0, '0, 4'hf, q);
            chk(q, rt[i]);
        end
    endtask

    task automatic lvlchk;
        logic [255:0] e;
        logic [6:0]   l;
        logic [31:0]  q;
        e = '0;
        for (int t = 0; t < 7; t++) begin
            l[t] = want[t] ^ (pl[t] == 1 && fn[t] != 18);
            if (l[t]) e[fn[t]] = 1'b1;
        end
        chk(terminal_level, l);
        chk(function_active, e);
        bus(96, 1'b0, '0, 4'hf, q);
        chk(q, {15'h0000, 1'b1, 1'b0, want, 1'b0, l});
        bus(100, 1'b0, '0, 4'hf, q);
        chk(q, e[31:0]);
    endtask

    initial begin
        #100_000;
        num_errors++;
        end_sim();
    end

    initial begin
        logic [31:0] q;
        fn = '{0, 1, 2, 3, 9, 18, 13};
        for (int i = 0; i < 7; i++) begin
            pl[i] = 0;
            rt[i] = 1;
        end
        void'($urandom(32'h140d));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (int n = 0; n < 50 && inputs_ready !== 1'b1; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        lvlchk();
        rdall();
        bus(8'h70, 1'b0, '0, 4'hf, q);
        chk(q, 0);
        drive_running <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wr(4 * i, $urandom % 256);
            wr(32 + 4 * i, 1);
            wr(64 + 4 * i, 0);
        end
        bus(104, 1'b0, '0, 4'hf, q);
        chk(q, 1);
        drive_running <= 1'b0;
        rdall();
        for (int i = 0; i < 7; i++) begin
            wr(64 + 4 * i, 201);
            wr(32 + 4 * i, 2);
            wr(4 * i, $urandom % 256, 4'he);
        end
        wr(52, 1);
        rdall();
        wr(32, 1);
        wr(0, 18);
        repeat (20) @(posedge clk);
        lvlchk();
        for (int k = 0; k < 12; k++) begin
            int t;
            t = $urandom % 7;
            wr(4 * t, $urandom % 20);
            wr(32 + 4 * t, $urandom % 2);
            wr(64 + 4 * t, $urandom % 3);
            want <= 7'($urandom);
            lag <= 4'($urandom % 4);
            repeat (60) @(posedge clk);
            lvlchk();
        end
        lag <= 4'h0;
        wr(0, 0);
        wr(32, 0);
        wr(64, 3);
        want <= 7'h00;
        repeat (60) @(posedge clk);
        want <= 7'h01;
        repeat (15) @(posedge clk);
        chk(terminal_level[0], 1'b0);
        repeat (25) @(posedge clk);
        chk(terminal_level[0], 1'b1);
        wr(64, 0);
        want <= 7'h00;
        repeat (8) @(posedge clk);
        chk(terminal_level[0], 1'b0);
        wr(64, 200);
        rdall();
        end_sim();
    end
endmodule
